// ---- beacon_pkg.sv ----
// Purpose: Shared constants for the beacon message framer
// Assumes: 10 MHz system clock
// Notes:   Field positions count from the last bit sent (bit 0)
package beacon_pkg;
  // Clock and timing
  localparam int CLK_HZ        = 10_000_000;
  localparam int GUARD_US      = 75;
  localparam int GUARD_CYC     = (GUARD_US * (CLK_HZ / 1_000_000));
  localparam int TURN_US       = 500;
  localparam int TURN_CYC_DEF  = TURN_US * (CLK_HZ / 1_000_000);
  localparam int SQ_MIN_MS     = 3800;
  localparam int SQ_MAX_MS     = 4200;
  localparam int SQ_MIN_DEF    = SQ_MIN_MS * (CLK_HZ / 1000);
  localparam int SQ_MAX_DEF    = SQ_MAX_MS * (CLK_HZ / 1000);
  localparam int GUARD_W       = $clog2(GUARD_CYC + 1);
  localparam int TURN_W        = $clog2(TURN_CYC_DEF + 1);
  localparam int SQ_W          = $clog2(SQ_MAX_DEF + 1);
  // Message sizes
  localparam int SHORT_W       = 56;
  localparam int LONG_W        = 112;
  localparam int AP_W          = 24;
  localparam int SHORT_INFO_W  = SHORT_W - AP_W;
  localparam int LONG_INFO_W   = LONG_W - AP_W;
  // Codes
  localparam logic [4:0]  FD_SHORT      = 5'h06;
  localparam logic [4:0]  FD_LONG       = 5'h16;
  localparam logic [2:0]  TYPE_NONE     = 3'h0;
  localparam logic [2:0]  TYPE_SQUITTER = 3'h1;
  localparam logic [2:0]  TYPE_REPLY    = 3'h2;
  localparam logic [2:0]  CONTENT_NONE  = 3'h0;
  localparam logic [2:0]  CONTENT_ACT   = 3'h1;
  localparam logic [2:0]  LEVEL_NONE    = 3'h0;
  localparam logic [23:0] BCAST_ADDR    = 24'hffffff;
  localparam logic [9:0]  RANGE_UNKNOWN = 10'h3ff;
  localparam logic [23:0] PARITY_POLY   = 24'h800063;
  localparam logic [14:0] REPLY_SPARE   = 15'h0000;
  // Interrogation field positions (low bit of each)
  localparam int RX_FD_LO    = 107;
  localparam int RX_CT_LO    = 104;
  localparam int RX_LR_LO    = 101;
  localparam int RX_ID_LO    = 88;
  localparam int RX_ADV_LO   = 74;
  localparam int RX_ALT_LO   = 61;
  localparam int RX_RNG_LO   = 51;
  localparam int RX_ACA_LO   = 27;
  localparam int RX_AP_LO    = 0;
endpackage : beacon_pkg

// ---- parity_if.sv ----
// Purpose: Carries an information field to a parity generator and back
// Assumes: Purely combinational link
// Notes:   One instance per message length
interface parity_if #(parameter int INFO_W = 32);
  logic [INFO_W-1:0] info;
  logic [23:0]       parity;
  modport gen  (input info, output parity);
  modport user (output info, input parity);
endinterface : parity_if

// ---- ap_parity.sv ----
// Purpose: 24 parity check bits over an information field
// Assumes: Information sent most significant bit first
// Notes:   Polynomial is a parameter
module ap_parity #(
  parameter int          INFO_W = 32,
  parameter logic [23:0] POLY   = beacon_pkg::PARITY_POLY
) (
  // Link to user
  parity_if.gen pif
);
  always_comb begin
    logic [23:0] crc;
    logic        fb;
    crc = 24'h000000;
    fb  = 1'b0;
    for (int i = INFO_W - 1; i >= 0; i--) begin
      fb  = pif.info[i] ^ crc[23];
      crc = {crc[22:0], 1'b0};
      if (fb) begin
        crc = crc ^ POLY;
      end
    end
    pif.parity = crc;
  end
endmodule : ap_parity

// ---- jitter_source.sv ----
// Purpose: Pseudo-random offset over 0..SPAN; folded low values come up twice as often
// Assumes: Free-running, advances every clock
// Notes:   Values above SPAN fold back once, which keeps the spread flat enough
module jitter_source #(
  parameter int SPAN = 4_000_000,
  parameter int W    = $clog2(SPAN + 1)
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst_n,
  // Offset
  output logic [W-1:0]      offset
);
  typedef struct packed {
    logic [31:0] lfsr;
  } jit_state_t;

  localparam logic [31:0] SEED = 32'h00000001;
  localparam logic [31:0] TAPS = 32'h80200003;
  localparam logic [W-1:0] SPAN_P1 = W'(SPAN + 1);

  jit_state_t st_ff;
  jit_state_t nxt_st;

  always_comb begin
    nxt_st = st_ff;
    nxt_st.lfsr = {1'b0, st_ff.lfsr[31:1]} ^ (st_ff.lfsr[0] ? TAPS : 32'h00000000);
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_ff <= '{lfsr: SEED};
    end else begin
      st_ff <= nxt_st;
    end
  end

  always_comb begin
    offset = st_ff.lfsr[W-1:0];
    if (st_ff.lfsr[W-1:0] >= SPAN_P1) begin
      offset = st_ff.lfsr[W-1:0] - SPAN_P1;
    end
  end
endmodule : jitter_source

// ---- beacon_message_framer.sv ----
// Purpose: Builds squitters and replies, decodes interrogations, schedules transmissions
// Assumes: Received message and sync mark come from on-clock signal processing
// Notes:   Pre-trigger is a pin and is synchronised
// Operation
// - Every outgoing message starts with format descriptor 6.
// - Message type is 1 for squitter, 2 for reply.
// - Squitter carries own 24-bit station address.
// - Squitter trailer is all-ones address over 24 parity bits.
// - Reply level command: zero for ranging reply, else 1 to 7.
// - Reply carries 6-bit range threshold in 16 us units.
// - Reply trailer is aircraft address over 24 parity bits.
// - Content type 0 means no data, 1 active data; others unassigned.
// - Identity, displayed advisory and altitude fields are extracted.
// - Range estimate is 10 bits in 2 us units.
// - All-ones range estimate gets a zero level command.
// - Reply goes to the interrogation's aircraft address.
// - Pre-trigger opens a 75 us guard with no transmission starts.
// - Squitter intervals uniform between 3.8 and 4.2 seconds; the folded jitter makes the shortest intervals twice as likely.
// - Squitter due in guard is sent after guard ends.
// - Reply start exactly 500 us after interrogation sync mark.
// - Reply due inside guard is cancelled.
// - One system clock times everything.
// - Parity-decoded address not ours: discard, no reply.
// - Prepared message released when its scheduled time is reached.
// - Format descriptor first and address/parity field last in every message.
module beacon_message_framer #(
  parameter int TURN_CYC = beacon_pkg::TURN_CYC_DEF,
  parameter int SQ_MIN   = beacon_pkg::SQ_MIN_DEF,
  parameter int SQ_MAX   = beacon_pkg::SQ_MAX_DEF,
  parameter int SLOTS    = 2
) (
  // Clock and reset
  input  wire logic                              clk,
  input  wire logic                              rst_n,
  // Station configuration
  input  wire logic [23:0]                       station_address,
  input  wire logic [2:0]                        level_command,
  input  wire logic [5:0]                        range_threshold,
  // Radar pre-trigger pin
  input  wire logic                              pretrigger_pin,
  // Received interrogations
  input  wire logic                              rx_sync_mark,
  input  wire logic                              rx_valid,
  input  wire logic [beacon_pkg::LONG_W-1:0]     rx_msg,
  // Decoded fields
  output logic                                   rx_fields_valid,
  output logic                                   rx_discard,
  output logic [2:0]                             level_report,
  output logic [12:0]                            identity_code_field,
  output logic [13:0]                            displayed_advisory,
  output logic [12:0]                            altitude_code,
  output logic [9:0]                             range_estimate,
  output logic [23:0]                            aircraft_address,
  // Transmit control
  output logic                                   tx_start,
  output logic                                   tx_is_reply,
  output logic [beacon_pkg::SHORT_W-1:0]         tx_msg,
  output logic                                   reply_cancel,
  output logic                                   guard_active
);
  localparam int SPAN  = SQ_MAX - SQ_MIN;
  localparam int JIT_W = $clog2(SPAN + 1);
  localparam int SW    = (SLOTS > 1) ? $clog2(SLOTS) : 1;
  localparam logic [beacon_pkg::GUARD_W-1:0] GUARD_LOAD = beacon_pkg::GUARD_W'(beacon_pkg::GUARD_CYC);
  localparam logic [beacon_pkg::TURN_W-1:0]  TURN_LOAD  = beacon_pkg::TURN_W'(TURN_CYC - 1);
  localparam logic [beacon_pkg::TURN_W-1:0]  TURN_ONE   = beacon_pkg::TURN_W'(1);
  localparam logic [beacon_pkg::SQ_W-1:0]    SQ_ONE     = beacon_pkg::SQ_W'(1);

  typedef struct packed {
    logic                         active;
    logic                         have_msg;
    logic [beacon_pkg::TURN_W-1:0] cnt;
    logic [23:0]                  dest;
    logic [2:0]                   level;
  } slot_t;

  typedef struct packed {
    logic                          pt_s1;
    logic                          pt_s2;
    logic                          pt_s3;
    logic [beacon_pkg::GUARD_W-1:0] guard_cnt;
    logic                          guard_on;
    logic [beacon_pkg::SQ_W-1:0]    sq_cnt;
    logic                          sq_pend;
    slot_t [SLOTS-1:0]             slot;
    logic                          rx_fields_valid;
    logic                          rx_discard;
    logic [2:0]                    level_report;
    logic [12:0]                   identity;
    logic [13:0]                   advisory;
    logic [12:0]                   altitude;
    logic [9:0]                    range_est;
    logic [23:0]                   aircraft;
    logic                          tx_start;
    logic                          tx_is_reply;
    logic [beacon_pkg::SHORT_W-1:0] tx_msg;
    logic                          reply_cancel;
  } framer_state_t;

  framer_state_t st_ff;
  framer_state_t nxt_st;

  logic [JIT_W-1:0] jitter;
  logic             fire_any;
  logic [SW-1:0]    fire_idx;
  logic             guard_now;
  logic             pt_rise;
  logic [23:0]      rx_ap_addr;
  logic             rx_ok;

  parity_if #(.INFO_W(beacon_pkg::SHORT_INFO_W)) tx_par ();
  parity_if #(.INFO_W(beacon_pkg::LONG_INFO_W))  rx_par ();

  ap_parity #(.INFO_W(beacon_pkg::SHORT_INFO_W), .POLY(beacon_pkg::PARITY_POLY)) u_tx_parity (
    .pif (tx_par)
  );

  ap_parity #(.INFO_W(beacon_pkg::LONG_INFO_W), .POLY(beacon_pkg::PARITY_POLY)) u_rx_parity (
    .pif (rx_par)
  );

  jitter_source #(.SPAN(SPAN), .W(JIT_W)) u_jitter (
    .clk    (clk),
    .rst_n  (rst_n),
    .offset (jitter)
  );

  // Guard window starts on the synchronised pre-trigger edge
  assign pt_rise   = st_ff.pt_s2 & ~st_ff.pt_s3;
  assign guard_now = pt_rise | (st_ff.guard_cnt != '0);

  // Interrogation check: parity stripped from the trailer must leave our address
  assign rx_par.info = rx_msg[beacon_pkg::LONG_W-1:beacon_pkg::AP_W];
  assign rx_ap_addr  = rx_msg[beacon_pkg::RX_AP_LO +: beacon_pkg::AP_W] ^ rx_par.parity;
  assign rx_ok = (rx_msg[beacon_pkg::RX_FD_LO +: 5] == beacon_pkg::FD_LONG)
               & (rx_msg[beacon_pkg::RX_CT_LO +: 3] == beacon_pkg::CONTENT_ACT)
               & (rx_ap_addr == station_address);

  // Oldest slot whose turnaround ends this cycle with a message ready
  always_comb begin
    fire_any = 1'b0;
    fire_idx = '0;
    for (int i = SLOTS - 1; i >= 0; i--) begin
      if (st_ff.slot[i].active && st_ff.slot[i].have_msg && st_ff.slot[i].cnt == TURN_ONE) begin
        fire_any = 1'b1;
        fire_idx = SW'(i);
      end
    end
  end

  // Info field of the next transmission, reply or squitter
  always_comb begin
    if (fire_any) begin
      tx_par.info = {beacon_pkg::FD_SHORT, beacon_pkg::TYPE_REPLY,
                     st_ff.slot[fire_idx].level, range_threshold,
                     beacon_pkg::REPLY_SPARE};
    end else begin
      tx_par.info = {beacon_pkg::FD_SHORT, beacon_pkg::TYPE_SQUITTER, station_address};
    end
  end

  always_comb begin
    logic placed;
    logic alloc;
    placed = 1'b0;
    alloc  = 1'b0;
    nxt_st = st_ff;
    nxt_st.pt_s1 = pretrigger_pin;
    nxt_st.pt_s2 = st_ff.pt_s1;
    nxt_st.pt_s3 = st_ff.pt_s2;
    nxt_st.rx_fields_valid = 1'b0;
    nxt_st.rx_discard      = 1'b0;
    nxt_st.tx_start        = 1'b0;
    nxt_st.reply_cancel    = 1'b0;

    if (pt_rise) begin
      nxt_st.guard_cnt = GUARD_LOAD;
    end else if (st_ff.guard_cnt != '0) begin
      nxt_st.guard_cnt = st_ff.guard_cnt - 1'b1;
    end
    // Registered copy keeps the guard output straight from a flop
    nxt_st.guard_on = (nxt_st.guard_cnt != '0);

    // Reply turnaround timers, one per slot
    for (int i = 0; i < SLOTS; i++) begin
      if (st_ff.slot[i].active) begin
        nxt_st.slot[i].cnt = st_ff.slot[i].cnt - 1'b1;
        if (st_ff.slot[i].cnt == TURN_ONE) begin
          nxt_st.slot[i].active = 1'b0;
          if (!st_ff.slot[i].have_msg) begin
            nxt_st.reply_cancel = 1'b1;
          end else if (fire_any && fire_idx == SW'(i)) begin
            if (guard_now) begin
              nxt_st.reply_cancel = 1'b1;
            end else begin
              nxt_st.tx_start    = 1'b1;
              nxt_st.tx_is_reply = 1'b1;
              nxt_st.tx_msg      = {tx_par.info, tx_par.parity ^ st_ff.slot[i].dest};
            end
          end else begin
            nxt_st.reply_cancel = 1'b1;
          end
        end
      end
    end

    // Squitter scheduling with jittered reload
    if (st_ff.sq_cnt == SQ_ONE) begin
      nxt_st.sq_cnt  = beacon_pkg::SQ_W'(SQ_MIN) + beacon_pkg::SQ_W'(jitter);
      nxt_st.sq_pend = 1'b1;
    end else begin
      nxt_st.sq_cnt = st_ff.sq_cnt - 1'b1;
    end
    if (st_ff.sq_pend && !guard_now && !fire_any) begin
      nxt_st.sq_pend     = (st_ff.sq_cnt == SQ_ONE);
      nxt_st.tx_start    = 1'b1;
      nxt_st.tx_is_reply = 1'b0;
      nxt_st.tx_msg      = {tx_par.info, tx_par.parity ^ beacon_pkg::BCAST_ADDR};
    end

    // Received interrogation joins the lowest-numbered slot still waiting for content
    if (rx_valid) begin
      for (int i = 0; i < SLOTS; i++) begin
        if (!placed && nxt_st.slot[i].active && !nxt_st.slot[i].have_msg) begin
          placed = 1'b1;
          if (rx_ok) begin
            nxt_st.slot[i].have_msg = 1'b1;
            nxt_st.slot[i].dest     = rx_msg[beacon_pkg::RX_ACA_LO +: 24];
            if (rx_msg[beacon_pkg::RX_RNG_LO +: 10] == beacon_pkg::RANGE_UNKNOWN) begin
              nxt_st.slot[i].level = beacon_pkg::LEVEL_NONE;
            end else begin
              nxt_st.slot[i].level = level_command;
            end
          end else begin
            nxt_st.slot[i].active = 1'b0;
          end
        end
      end
      if (rx_ok && placed) begin
        nxt_st.rx_fields_valid = 1'b1;
        nxt_st.level_report    = rx_msg[beacon_pkg::RX_LR_LO +: 3];
        nxt_st.identity        = rx_msg[beacon_pkg::RX_ID_LO +: 13];
        nxt_st.advisory        = rx_msg[beacon_pkg::RX_ADV_LO +: 14];
        nxt_st.altitude        = rx_msg[beacon_pkg::RX_ALT_LO +: 13];
        nxt_st.range_est       = rx_msg[beacon_pkg::RX_RNG_LO +: 10];
        nxt_st.aircraft        = rx_msg[beacon_pkg::RX_ACA_LO +: 24];
      end else begin
        nxt_st.rx_discard = 1'b1;
      end
    end

    // Sync mark starts a fresh turnaround in the lowest free slot
    if (rx_sync_mark) begin
      for (int i = 0; i < SLOTS; i++) begin
        if (!alloc && !nxt_st.slot[i].active) begin
          alloc = 1'b1;
          nxt_st.slot[i].active   = 1'b1;
          nxt_st.slot[i].have_msg = 1'b0;
          nxt_st.slot[i].cnt      = TURN_LOAD;
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_ff <= '0;
      st_ff.sq_cnt <= beacon_pkg::SQ_W'(SQ_MIN);
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign rx_fields_valid     = st_ff.rx_fields_valid;
  assign rx_discard          = st_ff.rx_discard;
  assign level_report        = st_ff.level_report;
  assign identity_code_field = st_ff.identity;
  assign displayed_advisory  = st_ff.advisory;
  assign altitude_code       = st_ff.altitude;
  assign range_estimate      = st_ff.range_est;
  assign aircraft_address    = st_ff.aircraft;
  assign tx_start            = st_ff.tx_start;
  assign tx_is_reply         = st_ff.tx_is_reply;
  assign tx_msg              = st_ff.tx_msg;
  assign reply_cancel        = st_ff.reply_cancel;
  assign guard_active        = st_ff.guard_on;
endmodule : beacon_message_framer

// ---- beacon_framer_assertions.sv ----
// Purpose: Port-level assertions for the beacon message framer
// Assumes: One clock, synchronous active-low reset
// Notes:   Guard length is counted in helper logic
module beacon_framer_assertions #(
  parameter int TURN_CYC = 5000
) (
  // Clock and reset
  input wire logic        clk,
  input wire logic        rst_n,
  // Inputs watched
  input wire logic [23:0] station_address,
  input wire logic        pretrigger_pin,
  input wire logic        rx_sync_mark,
  input wire logic        rx_valid,
  // Outputs watched
  input wire logic        rx_fields_valid,
  input wire logic        rx_discard,
  input wire logic [9:0]  range_estimate,
  input wire logic        tx_start,
  input wire logic        tx_is_reply,
  input wire logic [55:0] tx_msg,
  input wire logic        reply_cancel,
  input wire logic        guard_active
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic [10:0] guard_len_ff;
  always_ff @(posedge clk) guard_len_ff <= (rst_n && guard_active) ? guard_len_ff + 11'h1 : 11'h0;

  a_tx_format: assert property (tx_start |-> tx_msg[55:51] == 5'h06)
    else $error("Outgoing format descriptor wrong");
  a_tx_type: assert property (tx_start |-> tx_msg[50:48] == (tx_is_reply ? 3'h2 : 3'h1))
    else $error("Outgoing message type wrong");
  a_squit_addr: assert property (tx_start && !tx_is_reply |-> tx_msg[47:24] == station_address)
    else $error("Squitter station address wrong");
  a_reply_spare: assert property (tx_start && tx_is_reply |-> tx_msg[38:24] == 15'h0)
    else $error("Reply spare bits not zero");
  a_ranging_level: assert property (tx_start && tx_is_reply && range_estimate == 10'h3ff
    |-> tx_msg[47:45] == 3'h0) else $error("Ranging reply level not zero");
  a_reply_turn: assert property (tx_start && tx_is_reply |-> $past(rx_sync_mark, TURN_CYC))
    else $error("Reply not at turnaround time");
  a_guard_open: assert property ($rose(pretrigger_pin) |-> ##[1:5] guard_active)
    else $error("Pre-trigger opened no guard");
  a_guard_quiet: assert property (guard_active && $past(guard_active) |-> !tx_start)
    else $error("Transmission started in guard");
  a_guard_len: assert property ($fell(guard_active) |-> guard_len_ff >= 11'h2ed && guard_len_ff <= 11'h2ef)
    else $error("Guard length wrong");
  a_rx_answer: assert property (rx_valid |=> rx_fields_valid != rx_discard)
    else $error("Interrogation not accepted or discarded once");
  a_cancel_alone: assert property (reply_cancel |-> !(tx_start && tx_is_reply))
    else $error("Cancelled reply was sent");
  c_reply: cover property (tx_start && tx_is_reply);
  c_cancel: cover property (reply_cancel);
  c_discard: cover property (rx_discard);
endmodule : beacon_framer_assertions

// ---- air_unit.sv ----
// Purpose: Airborne unit sending interrogations to the framer
// Assumes: Driven from the bench through its send task
// Notes:   Released message lines show the inverse of the last word
module air_unit (
  // Clock
  input  wire logic         clk,
  // Replies from the ground unit
  input  wire logic         tx_start,
  input  wire logic         tx_is_reply,
  input  wire logic [55:0]  tx_msg,
  // Interrogation link
  output logic              rx_sync_mark,
  output logic              rx_valid,
  output logic [111:0]      rx_msg
);
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [12:0] ID  = 13'h1b2c;
  localparam logic [13:0] ADV = 14'h2d3e;
  localparam logic [12:0] ALT = 13'h0a5f;
  logic [2:0]             lr  = 3'h0;
  initial {rx_sync_mark, rx_valid, rx_msg} = '0;
  // Remember the last level command heard
  always @(posedge clk) begin
    if (tx_start && tx_is_reply) lr <= tx_msg[47:45];
  end

  function automatic logic [23:0] crc(input logic [87:0] d, input int n);
    logic [23:0] c;
    c = 24'h0;
    for (int i = n - 1; i >= 0; i--) c = {c[22:0], 1'b0} ^ ((c[23] ^ d[i]) ? beacon_pkg::PARITY_POLY : 24'h0);
    return c;
  endfunction : crc

  task automatic send(input logic [23:0] dest, input logic [2:0] ct, input logic [9:0] rng, input logic [23:0] acft);
    logic [87:0] info;
    info = {5'h16, ct, lr, ID, ADV, ALT, rng, acft, 3'h0};
    rx_sync_mark <= 1'b1;
    @(posedge clk);
    rx_sync_mark <= 1'b0;
    repeat (4) @(posedge clk);
    rx_valid <= 1'b1;
    rx_msg <= {info, crc(info, 88) ^ dest};
    @(posedge clk);
    rx_valid <= 1'b0;
    rx_msg <= ~rx_msg;
  endtask : send
endmodule : air_unit

// ---- beacon_message_framer_bench.sv ----
// Purpose: Self-checking bench for the beacon message framer
// Assumes: Shortened turnaround and squitter counts
// Notes:   A monitor logs replies and checks every squitter
module beacon_message_framer_bench;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int TC = 40;
  logic         clk = 1'b0;
  logic         rst_n = 1'b0;
  logic         pretrigger_pin = 1'b0;
  logic [23:0]  station_address = 24'h3a5c71;
  logic [2:0]   level_command = 3'h5;
  logic [5:0]   range_threshold = 6'h2d;
  logic         rx_sync_mark, rx_valid, rx_fields_valid, rx_discard;
  logic         tx_start, tx_is_reply, reply_cancel, guard_active;
  logic [2:0]   level_report;
  logic [12:0]  identity_code_field, altitude_code;
  logic [13:0]  displayed_advisory;
  logic [9:0]   range_estimate;
  logic [23:0]  aircraft_address;
  logic [111:0] rx_msg;
  logic [55:0]  tx_msg;
  logic [55:0]  rep_q[$];
  int           rep_t[$], mark_q[$];
  int           cyc, last_sq, gq, gf, base, n_fail, n_checks, n_acc, n_disc, n_cancel;

  always #50 clk = ~clk;
  beacon_message_framer #(.TURN_CYC(TC), .SQ_MIN(200), .SQ_MAX(260)) beacon_message_framer_inst (
    .clk (clk), .rst_n (rst_n), .station_address (station_address), .level_command (level_command),
    .range_threshold (range_threshold), .pretrigger_pin (pretrigger_pin), .rx_sync_mark (rx_sync_mark),
    .rx_valid (rx_valid), .rx_msg (rx_msg), .rx_fields_valid (rx_fields_valid), .rx_discard (rx_discard),
    .level_report (level_report), .identity_code_field (identity_code_field),
    .displayed_advisory (displayed_advisory), .altitude_code (altitude_code), .range_estimate (range_estimate),
    .aircraft_address (aircraft_address), .tx_start (tx_start), .tx_is_reply (tx_is_reply), .tx_msg (tx_msg),
    .reply_cancel (reply_cancel), .guard_active (guard_active)
  );
  air_unit air_unit_inst (
    .clk (clk), .tx_start (tx_start), .tx_is_reply (tx_is_reply), .tx_msg (tx_msg),
    .rx_sync_mark (rx_sync_mark), .rx_valid (rx_valid), .rx_msg (rx_msg)
  );

  function automatic logic [55:0] frame(input logic [2:0] ty, input logic [23:0] body, input logic [23:0] adr);
    logic [31:0] info;
    info = {5'h06, ty, body};
    return {info, air_unit_inst.crc({56'h0, info}, 32) ^ adr};
  endfunction : frame

  task automatic check(input string nm, input logic [55:0] seen, input logic [55:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  task automatic results;
    $display("Checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : results

  task automatic clear;
    rep_q.delete();
    rep_t.delete();
    mark_q.delete();
  endtask : clear

  task automatic expect_reply(input int i, input logic [2:0] lvl, input logic [23:0] acft);
    for (int k = 0; k < 3 * TC && rep_q.size() <= i; k++) @(posedge clk);
    if (rep_q.size() <= i) begin
      check("reply present", 56'h0, 56'h1);
      results();
    end
    check("reply", rep_q[i], frame(3'h2, {lvl, range_threshold, 15'h0}, acft));
    check("turnaround", 56'(rep_t[i] - mark_q[i]), 56'(TC));
  endtask : expect_reply

  // Log transfers; squitters checked as they go
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (rx_sync_mark) mark_q.push_back(cyc);
    if (rx_fields_valid) n_acc++;
    if (rx_discard) n_disc++;
    if (reply_cancel) n_cancel++;
    if (guard_active || (tx_start && tx_is_reply)) gq = 0;
    if (tx_start && tx_is_reply) begin
      rep_q.push_back(tx_msg);
      rep_t.push_back(cyc);
    end
    if (tx_start && !tx_is_reply) begin
      check("squitter", tx_msg, frame(3'h1, station_address, 24'hffffff));
      if (gq >= 2) check("squitter gap", 56'(cyc - last_sq >= 200 && cyc - last_sq <= 260), 56'h1);
      last_sq = cyc;
      gq++;
    end
  end

  initial begin
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    check("tx_msg at reset", tx_msg, 56'h0);
    check("address at reset", 56'(aircraft_address), 56'h0);
    // Ranging interrogation
    clear();
    air_unit_inst.send(station_address, 3'h1, 10'h3ff, 24'h6b1d40);
    expect_reply(0, 3'h0, 24'h6b1d40);
    check("accepted", 56'(n_acc), 56'h1);
    check("identity", 56'(identity_code_field), 56'(air_unit_inst.ID));
    check("advisory", 56'(displayed_advisory), 56'(air_unit_inst.ADV));
    check("altitude", 56'(altitude_code), 56'(air_unit_inst.ALT));
    check("range", 56'(range_estimate), 56'h3ff);
    // Two overlapping interrogations
    clear();
    air_unit_inst.send(station_address, 3'h1, 10'h0c8, 24'h1f0a33);
    air_unit_inst.send(station_address, 3'h1, 10'h0c9, 24'h2e7b04);
    expect_reply(0, level_command, 24'h1f0a33);
    expect_reply(1, level_command, 24'h2e7b04);
    check("level report", 56'(level_report), 56'h0);
    check("aircraft", 56'(aircraft_address), 56'h2e7b04);
    // Empty content, foreign address, unassigned content
    clear();
    base = n_disc;
    for (int k = 0; k < 3; k++) air_unit_inst.send(k == 1 ? ~station_address : station_address, 3'(k), 10'h010, 24'h00beef);
    repeat (2 * TC) @(posedge clk);
    check("discards", 56'(n_disc - base), 56'h3);
    check("no reply", 56'(rep_q.size()), 56'h0);
    // Guard cancels the reply and holds a squitter back
    clear();
    base = n_cancel;
    air_unit_inst.send(station_address, 3'h1, 10'h020, 24'h4c4c01);
    pretrigger_pin <= 1'b1;
    repeat (3) @(posedge clk);
    pretrigger_pin <= 1'b0;
    repeat (6) @(posedge clk);
    for (int k = 0; k < 1000 && guard_active !== 1'b0; k++) @(posedge clk);
    if (guard_active !== 1'b0) begin
      check("guard wait", 56'(guard_active), 56'h0);
      results();
    end
    gf = cyc;
    repeat (10) @(posedge clk);
    check("guard ended", 56'(guard_active), 56'h0);
    check("cancelled", 56'(n_cancel - base), 56'h1);
    check("no reply in guard", 56'(rep_q.size()), 56'h0);
    check("late squitter", 56'(last_sq >= gf - 3 && last_sq <= gf + 6), 56'h1);
    check("level report echo", 56'(level_report), 56'(level_command));
    repeat (800) @(posedge clk);
    results();
  end
endmodule : beacon_message_framer_bench

bind beacon_message_framer beacon_framer_assertions #(.TURN_CYC(TURN_CYC)) beacon_framer_assertions_inst (
  .clk (clk), .rst_n (rst_n), .station_address (station_address), .pretrigger_pin (pretrigger_pin),
  .rx_sync_mark (rx_sync_mark), .rx_valid (rx_valid), .rx_fields_valid (rx_fields_valid),
  .rx_discard (rx_discard), .range_estimate (range_estimate), .tx_start (tx_start), .tx_is_reply (tx_is_reply),
  .tx_msg (tx_msg), .reply_cancel (reply_cancel), .guard_active (guard_active)
);
